/* File: pkg/spw_defines.svh */
`ifndef SPW_DEFINES_SVH
`define SPW_DEFINES_SVH

// Register offsets (byte addresses on the 8-bit register port)
`define SPW_ADDR_W 8
`define SPW_DATA_W 8
`define SPW_OFF_WAKE_EN1 8'hB0
`define SPW_OFF_WAKE_EN2 8'hB1
`define SPW_OFF_IRQ_STATUS 8'hB4
`define SPW_OFF_IRQ_CLEAR 8'hB5
`define SPW_OFF_IRQ_ENABLE 8'hB6
`define SPW_OFF_POWER_STATE 8'hB7

// Reset values
`define SPW_RST_WAKE_EN1 8'h00
`define SPW_RST_WAKE_EN2 8'h80
`define SPW_RST_IRQ 8'h00
`define SPW_READ_UNMAPPED 8'h00

// Writable bits of the second enable register; the rest are reserved
`define SPW_WAKE_EN2_MASK 8'hAB

// Bits of the first wake enable register
`define SPW_EN1_UART1_RING 0
`define SPW_EN1_UART2_RING 1
`define SPW_EN1_KBD_CLK 2
`define SPW_EN1_MOUSE_CLK 3
`define SPW_EN1_GROUP_IRQ1 4
`define SPW_EN1_GROUP_IRQ2 5
`define SPW_EN1_IR_RX 6
`define SPW_EN1_ALARM 7

// Bits of the second wake enable register
`define SPW_EN2_UART1_RX 0
`define SPW_EN2_UART2_RX 1
`define SPW_EN2_RING 3
`define SPW_EN2_CIR 5
`define SPW_EN2_OFF 7

// Interrupt status / clear / enable bits
`define SPW_IRQ_WAKE 0
`define SPW_IRQ_BUTTON_OFF 1
`define SPW_IRQ_OFF_REFUSED 2
`define SPW_IRQ_BUTTON_ON 3
`define SPW_IRQ_BITS 4

// Power state register bits
`define SPW_PST_ON 0
`define SPW_PST_BUTTON 1

// Timing
`define SPW_CLK_PERIOD_NS 25
`define SPW_DEBOUNCE_NS 16000000
`define SPW_DEBOUNCE_CYCLES (`SPW_DEBOUNCE_NS / `SPW_CLK_PERIOD_NS)

// Pin synchroniser count
`define SPW_PIN_COUNT 10

`endif

/* File: pkg/spw_pkg.sv */
package spw_pkg;

    typedef enum logic [1:0] {
        SPW_ST_OFF = 2'b01,
        SPW_ST_ON = 2'b10
    } spw_power_state_t;

endpackage : spw_pkg

/* File: rtl/spw_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module spw_pin_sync
    import spw_pkg::*;
#(
    parameter int N = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [N-1:0] pin_i,
    output logic [N-1:0] level_o,
    output logic [N-1:0] fall_o
);

    // Pins idle high; a change counts only once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            logic s1;
            logic s2;
            logic s3;
            logic lvl;
            logic fall;
            wire agree = (s2 == s3);
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    s1 <= 1'b1;
                    s2 <= 1'b1;
                    s3 <= 1'b1;
                    lvl <= 1'b1;
                    fall <= 1'b0;
                end else begin
                    s1 <= pin_i[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (agree) begin
                        lvl <= s3;
                    end
                    fall <= agree & lvl & ~s3;
                end
            end
            assign level_o[g] = lvl;
            assign fall_o[g] = fall;
        end
    endgenerate

endmodule : spw_pin_sync

`default_nettype wire

/* File: rtl/spw_power_ctl.sv */
`timescale 1ns/1ps
`default_nettype none

module spw_power_ctl
    import spw_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic wake_i,
    input wire logic button_press_i,
    input wire logic off_en_i,
    output logic power_on_n_o,
    output logic went_on_wake_o,
    output logic went_on_button_o,
    output logic went_off_o,
    output logic off_refused_o
);

    spw_power_state_t state;
    spw_power_state_t next_state;

    wire go_on_wake = (state == SPW_ST_OFF) & wake_i;
    wire go_on_button = (state == SPW_ST_OFF) & button_press_i & ~wake_i;
    wire go_off = (state == SPW_ST_ON) & button_press_i & off_en_i;
    wire refuse = (state == SPW_ST_ON) & button_press_i & ~off_en_i;

    always_comb begin
        next_state = state;
        unique case (state)
            SPW_ST_OFF: begin
                if (go_on_wake | go_on_button) begin
                    next_state = SPW_ST_ON;
                end
            end
            SPW_ST_ON: begin
                if (go_off) begin
                    next_state = SPW_ST_OFF;
                end
            end
            default: begin
                next_state = SPW_ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= SPW_ST_OFF;
            power_on_n_o <= 1'b1;
            went_on_wake_o <= 1'b0;
            went_on_button_o <= 1'b0;
            went_off_o <= 1'b0;
            off_refused_o <= 1'b0;
        end else begin
            state <= next_state;
            power_on_n_o <= (next_state != SPW_ST_ON);
            went_on_wake_o <= go_on_wake;
            went_on_button_o <= go_on_button;
            went_off_o <= go_off;
            off_refused_o <= refuse;
        end
    end

endmodule : spw_power_ctl

`default_nettype wire

/* File: rtl/spw_wake_top.sv */
// The plain strobed port was left to the implementer.
`include "spw_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module spw_wake_top
    import spw_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = `SPW_DEBOUNCE_CYCLES
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic SUPPLY_RSTN_I,
    input wire logic [`SPW_ADDR_W-1:0] ADDR_I,
    input wire logic [`SPW_DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [`SPW_DATA_W-1:0] RDATA_O,
    input wire logic UART1_RING_N_I,
    input wire logic UART2_RING_N_I,
    input wire logic KEYBOARD_CLOCK_PIN_I,
    input wire logic MOUSE_CLOCK_PIN_I,
    input wire logic IR_RECEIVE_INPUT_2_I,
    input wire logic UART1_RX_I,
    input wire logic UART2_RX_I,
    input wire logic RING_INPUT_N_I,
    input wire logic POWER_BUTTON_N_I,
    input wire logic GROUP_INTERRUPT_1_I,
    input wire logic GROUP_INTERRUPT_2_I,
    input wire logic ALARM_I,
    input wire logic CONSUMER_IR_WAKE_I,
    output logic POWER_ON_REQUEST_N_O,
    output logic IRQ_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    localparam int PINS = `SPW_PIN_COUNT;
    localparam int PIN_RI1 = 0;
    localparam int PIN_RI2 = 1;
    localparam int PIN_KBD = 2;
    localparam int PIN_MOUSE = 3;
    localparam int PIN_IR = 4;
    localparam int PIN_RX1 = 5;
    localparam int PIN_RX2 = 6;
    localparam int PIN_RING = 7;
    localparam int PIN_BUTTON = 8;
    localparam int PIN_SUPPLY = 9;

    wire [PINS-1:0] pins_raw = {
        SUPPLY_RSTN_I,
        POWER_BUTTON_N_I,
        RING_INPUT_N_I,
        UART2_RX_I,
        UART1_RX_I,
        IR_RECEIVE_INPUT_2_I,
        MOUSE_CLOCK_PIN_I,
        KEYBOARD_CLOCK_PIN_I,
        UART2_RING_N_I,
        UART1_RING_N_I
    };
    logic [PINS-1:0] pin_level;
    logic [PINS-1:0] pin_fall;

    spw_pin_sync #(
        .N(PINS)
    ) u_sync (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .pin_i(pins_raw),
        .level_o(pin_level),
        .fall_o(pin_fall)
    );

    // Main supply or host bus reset, already synchronised; clears the
    // volatile side only, never the battery-backed enables
    wire supply_reset = ~pin_level[PIN_SUPPLY];

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode

    wire hit_en1 = (ADDR_I == `SPW_OFF_WAKE_EN1);
    wire hit_en2 = (ADDR_I == `SPW_OFF_WAKE_EN2);
    wire hit_status = (ADDR_I == `SPW_OFF_IRQ_STATUS);
    wire hit_clear = (ADDR_I == `SPW_OFF_IRQ_CLEAR);
    wire hit_irq_en = (ADDR_I == `SPW_OFF_IRQ_ENABLE);
    wire hit_pstate = (ADDR_I == `SPW_OFF_POWER_STATE);

    wire wr_en1 = WR_I & hit_en1;
    wire wr_en2 = WR_I & hit_en2;
    wire wr_clear = WR_I & hit_clear;
    wire wr_irq_en = WR_I & hit_irq_en;

    ////////////////////////////////////////////////////////////////////////////
    // Battery-backed wake enables

    logic [`SPW_DATA_W-1:0] wake_source_enable_1;
    logic [`SPW_DATA_W-1:0] wake_source_enable_2;

    // Only the battery reset returns these to defaults; supply_reset is
    // deliberately left out so enables survive a main power cycle
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wake_source_enable_1 <= `SPW_RST_WAKE_EN1;
            wake_source_enable_2 <= `SPW_RST_WAKE_EN2;
        end else begin
            if (wr_en1) begin
                wake_source_enable_1 <= WDATA_I;
            end
            if (wr_en2) begin
                wake_source_enable_2 <= WDATA_I & `SPW_WAKE_EN2_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake sources, laid out like the enable registers

    logic [`SPW_DATA_W-1:0] src1;
    logic [`SPW_DATA_W-1:0] src2;

    always_comb begin
        src1 = 8'h00;
        src1[`SPW_EN1_UART1_RING] = pin_fall[PIN_RI1];
        src1[`SPW_EN1_UART2_RING] = pin_fall[PIN_RI2];
        src1[`SPW_EN1_KBD_CLK] = pin_fall[PIN_KBD];
        src1[`SPW_EN1_MOUSE_CLK] = pin_fall[PIN_MOUSE];
        src1[`SPW_EN1_GROUP_IRQ1] = GROUP_INTERRUPT_1_I;
        src1[`SPW_EN1_GROUP_IRQ2] = GROUP_INTERRUPT_2_I;
        src1[`SPW_EN1_IR_RX] = pin_fall[PIN_IR];
        src1[`SPW_EN1_ALARM] = ALARM_I;
    end

    // Bit 7 of the second register is the power-off enable, not a source
    always_comb begin
        src2 = 8'h00;
        src2[`SPW_EN2_UART1_RX] = pin_fall[PIN_RX1];
        src2[`SPW_EN2_UART2_RX] = pin_fall[PIN_RX2];
        src2[`SPW_EN2_RING] = pin_fall[PIN_RING];
        src2[`SPW_EN2_CIR] = CONSUMER_IR_WAKE_I;
    end

    wire [`SPW_DATA_W-1:0] hit1 = src1 & wake_source_enable_1;
    wire [`SPW_DATA_W-1:0] hit2 = src2 & wake_source_enable_2;
    wire wake_request = (|hit1) | (|hit2);
    wire off_enable = wake_source_enable_2[`SPW_EN2_OFF];

    ////////////////////////////////////////////////////////////////////////////
    // Power button debounce

    // A bouncing button must not toggle power twice; the price is that a
    // press shorter than the debounce time is ignored
    localparam int DB_W = $clog2(DEBOUNCE_CYCLES + 1);
    localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYCLES - 1);

    logic [DB_W-1:0] db_count;
    logic button_stable;
    logic button_press;

    wire button_now = pin_level[PIN_BUTTON];
    wire button_differs = (button_now != button_stable);
    wire db_done = button_differs & (db_count == DB_LAST);

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            db_count <= '0;
            button_stable <= 1'b1;
            button_press <= 1'b0;
        end else begin
            button_press <= db_done & button_stable;
            if (!button_differs || db_done) begin
                db_count <= '0;
            end else begin
                db_count <= db_count + DB_W'(1);
            end
            if (db_done) begin
                button_stable <= button_now;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power state

    logic power_on_n;
    logic ev_wake;
    logic ev_button_on;
    logic ev_off;
    logic ev_refused;

    spw_power_ctl u_power (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .wake_i(wake_request),
        .button_press_i(button_press),
        .off_en_i(off_enable),
        .power_on_n_o(power_on_n),
        .went_on_wake_o(ev_wake),
        .went_on_button_o(ev_button_on),
        .went_off_o(ev_off),
        .off_refused_o(ev_refused)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, clear and enable

    logic [`SPW_IRQ_BITS-1:0] irq_status;
    logic [`SPW_IRQ_BITS-1:0] irq_enable;
    logic [`SPW_IRQ_BITS-1:0] irq_event;

    always_comb begin
        irq_event = '0;
        irq_event[`SPW_IRQ_WAKE] = ev_wake;
        irq_event[`SPW_IRQ_BUTTON_OFF] = ev_off;
        irq_event[`SPW_IRQ_OFF_REFUSED] = ev_refused;
        irq_event[`SPW_IRQ_BUTTON_ON] = ev_button_on;
    end

    wire [`SPW_IRQ_BITS-1:0] clr_bits = wr_clear ? WDATA_I[`SPW_IRQ_BITS-1:0] : '0;
    // Set wins over a clear landing in the same cycle
    wire [`SPW_IRQ_BITS-1:0] next_status = (irq_status & ~clr_bits) | irq_event;
    wire [`SPW_IRQ_BITS-1:0] next_enable =
        wr_irq_en ? WDATA_I[`SPW_IRQ_BITS-1:0] : irq_enable;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            irq_status <= '0;
            irq_enable <= '0;
            IRQ_O <= 1'b0;
        end else if (supply_reset) begin
            irq_status <= '0;
            irq_enable <= '0;
            IRQ_O <= 1'b0;
        end else begin
            irq_status <= next_status;
            irq_enable <= next_enable;
            IRQ_O <= |(next_status & next_enable);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and power request output

    wire [`SPW_DATA_W-1:0] status_word = {{(`SPW_DATA_W-`SPW_IRQ_BITS){1'b0}}, irq_status};
    wire [`SPW_DATA_W-1:0] enable_word = {{(`SPW_DATA_W-`SPW_IRQ_BITS){1'b0}}, irq_enable};
    logic [`SPW_DATA_W-1:0] pstate_word;

    always_comb begin
        pstate_word = 8'h00;
        pstate_word[`SPW_PST_ON] = ~power_on_n;
        pstate_word[`SPW_PST_BUTTON] = ~button_stable;
    end

    // The clear register is write-only and reads as zero
    wire [`SPW_DATA_W-1:0] next_rdata =
        hit_en1 ? wake_source_enable_1 :
        hit_en2 ? wake_source_enable_2 :
        hit_status ? status_word :
        hit_irq_en ? enable_word :
        hit_pstate ? pstate_word :
        `SPW_READ_UNMAPPED;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            RDATA_O <= `SPW_READ_UNMAPPED;
            POWER_ON_REQUEST_N_O <= 1'b1;
        end else begin
            RDATA_O <= RD_I ? next_rdata : `SPW_READ_UNMAPPED;
            POWER_ON_REQUEST_N_O <= power_on_n;
        end
    end

endmodule : spw_wake_top

`default_nettype wire

/* File: dv/spw_wake_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module spw_wake_top_chk
    import spw_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = 4
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic SUPPLY_RSTN_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic UART1_RING_N_I,
    input wire logic KEYBOARD_CLOCK_PIN_I,
    input wire logic MOUSE_CLOCK_PIN_I,
    input wire logic UART1_RX_I,
    input wire logic RING_INPUT_N_I,
    input wire logic GROUP_INTERRUPT_1_I,
    input wire logic GROUP_INTERRUPT_2_I,
    input wire logic ALARM_I,
    input wire logic CONSUMER_IR_WAKE_I,
    input wire logic POWER_ON_REQUEST_N_O,
    input wire logic IRQ_O
);
    // Shadow enables; only the battery reset clears them, never the supply reset
    logic [7:0] en1;
    logic [7:0] en2;
    wire wr1 = WR_I && ADDR_I == 8'hB0;
    wire wr2 = WR_I && ADDR_I == 8'hB1;
    wire off = POWER_ON_REQUEST_N_O;
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            en1 <= 8'h00;
            en2 <= 8'h80;
        end else begin
            if (wr1) en1 <= WDATA_I;
            if (wr2) en2 <= WDATA_I & 8'hAB;
        end
    end
    ////////////////////////////////////////////////
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    AST_RDATA_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data outside its slot");
    AST_READ_EN1: assert property (RD_I && ADDR_I == 8'hB0 |=> RDATA_O == en1)
        else $error("enable 1 readback wrong");
    AST_READ_EN2: assert property (RD_I && ADDR_I == 8'hB1 |=> RDATA_O == en2)
        else $error("enable 2 readback wrong");
    AST_GRP_WAKE: assert property (off && (en1[4] && GROUP_INTERRUPT_1_I
        || en1[5] && GROUP_INTERRUPT_2_I) |-> ##2 !off) else $error("group wake missed");
    AST_ALARM_WAKE: assert property (off && en1[7] && ALARM_I |-> ##2 !off)
        else $error("alarm wake missed");
    AST_CIR_WAKE: assert property (off && en2[5] && CONSUMER_IR_WAKE_I |-> ##2 !off)
        else $error("consumer IR wake missed");
    AST_CLK_WAKE: assert property (off && ($fell(KEYBOARD_CLOCK_PIN_I) && en1[2]
        || $fell(MOUSE_CLOCK_PIN_I) && en1[3]) |-> ##[1:6] !off) else $error("clock wake missed");
    AST_RING_WAKE: assert property (off && $fell(RING_INPUT_N_I) && en2[3]
        |-> ##[1:6] !off) else $error("ring wake missed");
    AST_UART_WAKE: assert property (off && ($fell(UART1_RING_N_I) && en1[0]
        || $fell(UART1_RX_I) && en2[0]) |-> ##[1:6] !off) else $error("uart wake missed");
    AST_OFF_GATED: assert property ($rose(off) |-> en2[7])
        else $error("power off while button off disabled");
    AST_IRQ_SUPPLY: assert property (!SUPPLY_RSTN_I [*6] |-> !IRQ_O)
        else $error("interrupt during supply reset");
endmodule : spw_wake_top_chk

bind spw_wake_top spw_wake_top_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) chk_i (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .SUPPLY_RSTN_I(SUPPLY_RSTN_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .UART1_RING_N_I(UART1_RING_N_I), .KEYBOARD_CLOCK_PIN_I(KEYBOARD_CLOCK_PIN_I),
    .MOUSE_CLOCK_PIN_I(MOUSE_CLOCK_PIN_I), .UART1_RX_I(UART1_RX_I),
    .RING_INPUT_N_I(RING_INPUT_N_I), .GROUP_INTERRUPT_1_I(GROUP_INTERRUPT_1_I),
    .GROUP_INTERRUPT_2_I(GROUP_INTERRUPT_2_I), .ALARM_I(ALARM_I),
    .CONSUMER_IR_WAKE_I(CONSUMER_IR_WAKE_I), .POWER_ON_REQUEST_N_O(POWER_ON_REQUEST_N_O),
    .IRQ_O(IRQ_O)
);
`default_nettype wire

/* File: dv/spw_psu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module spw_psu_model
    import spw_pkg::*;
#(
    parameter int HOLD = 12,
    parameter int PG_DELAY = 3
) (
    input wire logic clk_i,
    input wire logic power_on_n_i,
    input wire logic press_i,
    output logic button_n_o,
    output logic power_good_o
);
    // Held switch: line low from each press_i pulse until HOLD cycles after it ends, pulled up otherwise
    int hold_cnt = 0;
    int pg_cnt = 0;
    assign button_n_o = (hold_cnt == 0);
    assign power_good_o = (pg_cnt == PG_DELAY);
    ////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (press_i) begin
            hold_cnt <= HOLD;
        end else if (hold_cnt > 0) begin
            hold_cnt <= hold_cnt - 1;
        end
        // Supply ramps slowly but collapses at once when the request goes
        if (power_on_n_i !== 1'b0) begin
            pg_cnt <= 0;
        end else if (pg_cnt < PG_DELAY) begin
            pg_cnt <= pg_cnt + 1;
        end
    end
endmodule : spw_psu_model
`default_nettype wire

/* File: dv/spw_wake_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module spw_wake_top_tb
    import spw_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic srst_n = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic press = 1'b0;
    logic [11:0] ev = 12'h000;
    logic [7:0] rdata;
    logic btn_n;
    logic pwr_n;
    logic irq;
    logic pg;
    int error_cnt = 0;
    int compares = 0;
    always #12.5 clk = ~clk;
    // Event bits are active high; pins idle high, so those see the inverse
    spw_wake_top #(.DEBOUNCE_CYCLES(4)) spw_wake_top_i (
        .CLK_I(clk), .RSTN_I(rstn), .SUPPLY_RSTN_I(srst_n), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .UART1_RING_N_I(~ev[0]), .UART2_RING_N_I(~ev[1]),
        .KEYBOARD_CLOCK_PIN_I(~ev[2]), .MOUSE_CLOCK_PIN_I(~ev[3]),
        .GROUP_INTERRUPT_1_I(ev[4]), .GROUP_INTERRUPT_2_I(ev[5]),
        .IR_RECEIVE_INPUT_2_I(~ev[6]), .ALARM_I(ev[7]), .UART1_RX_I(~ev[8]),
        .UART2_RX_I(~ev[9]), .RING_INPUT_N_I(~ev[10]), .CONSUMER_IR_WAKE_I(ev[11]),
        .POWER_BUTTON_N_I(btn_n), .POWER_ON_REQUEST_N_O(pwr_n), .IRQ_O(irq)
    );
    spw_psu_model spw_psu_model_i (.clk_i(clk), .power_on_n_i(pwr_n), .press_i(press),
        .button_n_o(btn_n), .power_good_o(pg));
    ////////////////////////////////////////////////
    task automatic end_sim();
        if (error_cnt == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr8
    task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd8
    // Bounded wait on the power request; running out ends the run
    task automatic wait_p(input logic v);
        int n;
        n = 0;
        while (pwr_n !== v && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({7'h00, pwr_n}, {7'h00, v});
        if (pwr_n !== v) end_sim();
    endtask : wait_p
    task automatic fire(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        cyc(3);
        ev[i] <= 1'b0;
    endtask : fire
    task automatic push();
        @(posedge clk);
        press <= 1'b1;
        @(posedge clk);
        press <= 1'b0;
    endtask : push
    ////////////////////////////////////////////////
    task automatic t_regs();
        rd8(8'hB0, 8'h00);
        rd8(8'hB1, 8'h80);
        wr8(8'hB0, 8'hA5);
        wr8(8'hB1, 8'hFF);
        rd8(8'hB0, 8'hA5);
        rd8(8'hB1, 8'hAB);
        wr8(8'h10, 8'hFF);
        rd8(8'h10, 8'h00);
        @(posedge clk);
        rstn <= 1'b0;
        cyc(2);
        rstn <= 1'b1;
        rd8(8'hB0, 8'h00);
        rd8(8'hB1, 8'h80);
    endtask : t_regs
    task automatic t_sources();
        logic [7:0] m;
        int sh;
        for (int i = 0; i < 12; i++) begin
            sh = (i < 8) ? i : (i == 8) ? 0 : (i == 9) ? 1 : (i == 10) ? 3 : 5;
            m = 8'h01 << sh;
            wr8(8'hB0, 8'h00);
            wr8(8'hB1, 8'h80);
            fire(i);
            cyc(10);
            #1;
            chk({7'h00, pwr_n}, 8'h01);
            wr8((i < 8) ? 8'hB0 : 8'hB1, (i < 8) ? m : (m | 8'h80));
            fire(i);
            wait_p(1'b0);
            push();
            wait_p(1'b1);
            cyc(20);
        end
    endtask : t_sources
    task automatic t_irq();
        wr8(8'hB5, 8'hFF);
        wr8(8'hB0, 8'h80);
        fire(7);
        wait_p(1'b0);
        cyc(3);
        #1;
        chk({7'h00, irq}, 8'h00);
        chk({7'h00, pg}, 8'h01);
        rd8(8'hB4, 8'h01);
        rd8(8'hB7, 8'h01);
        wr8(8'hB6, 8'h01);
        cyc(2);
        #1;
        chk({7'h00, irq}, 8'h01);
        wr8(8'hB5, 8'h01);
        cyc(2);
        #1;
        chk({7'h00, irq}, 8'h00);
        wr8(8'hB6, 8'h01);
        fire(7);
        @(posedge clk);
        srst_n <= 1'b0;
        cyc(8);
        #1;
        chk({7'h00, irq}, 8'h00);
        srst_n <= 1'b1;
        cyc(6);
        rd8(8'hB0, 8'h80);
        wr8(8'hB1, 8'h00);
        push();
        cyc(20);
        #1;
        chk({7'h00, pwr_n}, 8'h00);
        rd8(8'hB4, 8'h04);
        wr8(8'hB1, 8'h80);
        push();
        wait_p(1'b1);
        // Let the held button release and settle, or the next press merges
        cyc(20);
        push();
        wait_p(1'b0);
        rd8(8'hB4, 8'h0E);
    endtask : t_irq
    ////////////////////////////////////////////////
    initial begin
        cyc(2);
        rstn <= 1'b1;
        t_regs();
        t_sources();
        t_irq();
        end_sim();
    end
endmodule : spw_wake_top_tb
`default_nettype wire
